// ### rtl/vrls_top.sv
// Decided for this implementation: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// one link: reference search, locks, crc flags, payload id
module vrls_link (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [9:0]  word,
  input  wire logic        wordValid,
  input  wire logic [10:0] lnIn,
  input  wire logic        lnValid,
  input  wire logic        crcChk,
  input  wire logic        crcBadY,
  input  wire logic        crcBadC,
  input  wire logic [31:0] vpidIn,
  input  wire logic        vpidStb,
  input  wire logic        vpidSumOk,
  input  wire logic        crcEn,
  input  wire logic        vpidEn,
  input  wire logic        sdMode,
  output logic             trsStart,
  output logic             alignLock,
  output logic             looseLock,
  output logic             trsLock,
  output logic             frameLock,
  output logic             crcErrY,
  output logic             crcErrC,
  output logic [31:0]      vpid,
  output logic             vpidValid,
  output logic             vpidSumErr,
  output logic [10:0]      lineNum,
  output logic             lostEv,
  output logic             crcEv,
  output logic             sumEv
);
  localparam int W = vrls_pkg::CNT_W;

  // whole link state in one record
  typedef struct packed {
    logic [9:0]   w1;     // previous word
    logic [9:0]   w2;     // word before that
    logic [W-1:0] pos;    // words since last reference
    logic [W-1:0] iv1;    // last interval
    logic [W-1:0] iv2;    // interval before that
    logic [2:0]   mTrs;   // matching references in a row
    logic [W-1:0] fpos;   // words since frame start
    logic [W-1:0] fLen;   // last frame length
    logic [1:0]   mFr;    // matching frames in a row
    logic         trs;
    logic         align;
    logic         loose;
    logic         tLock;
    logic         fLock;
    logic         cY;
    logic         cC;
    logic [31:0]  vp;
    logic         vVal;
    logic         vErr;
    logic [10:0]  ln;
    logic         lost;
    logic         cEv;
    logic         sEv;
  } vrls_link_t;

  vrls_link_t s;
  vrls_link_t next_s;
  logic       isTrs;      // pattern completes on this word
  logic       isFrame;    // line counter wraps to frame start

  // next-state logic
  always_comb begin
    next_s = s;
    next_s.trs = 1'b0;
    next_s.lost = 1'b0;
    next_s.cEv = 1'b0;
    next_s.sEv = 1'b0;
    isTrs = wordValid && s.w2 == vrls_pkg::TRS_ONES
            && s.w1 == vrls_pkg::TRS_ZERO
            && word == vrls_pkg::TRS_ZERO;
    isFrame = lnValid && lnIn == vrls_pkg::LN_FIRST
              && s.ln != vrls_pkg::LN_FIRST;
    if (wordValid) begin
      next_s.w1 = word;
      next_s.w2 = s.w1;
      next_s.fpos = s.fpos + W'(1);
      // counter saturates at the timeout
      if (s.pos != vrls_pkg::TRS_TIMEOUT) begin
        next_s.pos = s.pos + W'(1);
      end
    end
    if (isTrs) begin
      // pulse marks the pattern that began with 3FF
      next_s.trs = 1'b1;
      next_s.align = 1'b1;
      next_s.loose = 1'b1;
      next_s.pos = '0;
      next_s.iv1 = s.pos;
      next_s.iv2 = s.iv1;
      // eav and sav alternate, so compare two back
      if (s.pos == s.iv2) begin
        if (s.mTrs != vrls_pkg::TRS_LOCK_N) begin
          next_s.mTrs = s.mTrs + 3'h1;
        end
      end else begin
        // timing moved: drop both locks
        next_s.mTrs = '0;
        next_s.tLock = 1'b0;
        next_s.fLock = 1'b0;
        next_s.lost = s.tLock;
      end
      if (next_s.mTrs == vrls_pkg::TRS_LOCK_N) begin
        next_s.tLock = 1'b1;
      end
    end else if (s.pos == vrls_pkg::TRS_TIMEOUT) begin
      // no reference for too long: stream gone
      next_s.align = 1'b0;
      next_s.loose = 1'b0;
      next_s.tLock = 1'b0;
      next_s.fLock = 1'b0;
      next_s.mTrs = '0;
      next_s.lost = s.tLock;
    end
    // frame timing compared frame by frame
    if (lnValid) begin
      next_s.ln = lnIn;
    end
    if (isFrame) begin
      next_s.fpos = '0;
      next_s.fLen = s.fpos;
      if (s.fpos == s.fLen) begin
        if (s.mFr != vrls_pkg::FRAME_LOCK_N) begin
          next_s.mFr = s.mFr + 2'h1;
        end
      end else begin
        next_s.mFr = '0;
        next_s.fLock = 1'b0;
        next_s.lost = next_s.lost | s.fLock;
      end
      if (next_s.mFr == vrls_pkg::FRAME_LOCK_N
          && next_s.tLock) begin
        next_s.fLock = 1'b1;
      end
    end
    // crc flags hold until the next check, and clear while crc is off or in sd mode
    if (crcChk) begin
      next_s.cY = crcEn && !sdMode && crcBadY;
      next_s.cC = crcEn && !sdMode && crcBadC;
      next_s.cEv = next_s.cY || next_s.cC;
    end
    if (!crcEn || sdMode) begin
      next_s.cY = 1'b0;
      next_s.cC = 1'b0;
    end
    // payload id taken whole, with checksum verdict
    if (vpidStb && vpidEn) begin
      next_s.vp = vpidIn;
      next_s.vVal = vpidSumOk;
      next_s.vErr = !vpidSumOk;
      next_s.sEv = !vpidSumOk;
    end
    // stale id is not valid once the lock is gone
    if (!vpidEn || !next_s.tLock) begin
      next_s.vVal = 1'b0;
    end
    if (!vpidEn) begin
      next_s.vErr = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign trsStart   = s.trs;
  assign alignLock  = s.align;
  assign looseLock  = s.loose;
  assign trsLock    = s.tLock;
  assign frameLock  = s.fLock;
  assign crcErrY    = s.cY;
  assign crcErrC    = s.cC;
  assign vpid       = s.vp;
  assign vpidValid  = s.vVal;
  assign vpidSumErr = s.vErr;
  assign lineNum    = s.ln;
  assign lostEv     = s.lost;
  assign crcEv      = s.cEv;
  assign sumEv      = s.sEv;
endmodule : vrls_link

module vrls_top (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             irq,
  input  wire logic        sdMode,
  input  wire logic [9:0]  wordA,
  input  wire logic        wordValidA,
  input  wire logic [10:0] lnInA,
  input  wire logic        lnValidA,
  input  wire logic        crcChkA,
  input  wire logic        crcBadYA,
  input  wire logic        crcBadCA,
  input  wire logic [31:0] vpidInA,
  input  wire logic        vpidStbA,
  input  wire logic        vpidSumOkA,
  input  wire logic [9:0]  wordB,
  input  wire logic        wordValidB,
  input  wire logic [10:0] lnInB,
  input  wire logic        lnValidB,
  input  wire logic        crcChkB,
  input  wire logic        crcBadYB,
  input  wire logic        crcBadCB,
  input  wire logic [31:0] vpidInB,
  input  wire logic        vpidStbB,
  input  wire logic        vpidSumOkB,
  output logic             trsStart,
  output logic             trsStartB,
  output logic             alignLock,
  output logic             alignLockB,
  output logic             trsLock,
  output logic             trsLockB,
  output logic             frameLock,
  output logic             frameLockB,
  output logic             dual_link_lock,
  output logic             looseLock,
  output logic             looseLockB,
  output logic             crcErrY,
  output logic             crcErrC,
  output logic             crcErrYB,
  output logic             crcErrCB,
  output logic [7:0]       payload_ident_first_byte,
  output logic [7:0]       payload_ident_second_byte,
  output logic [7:0]       payload_ident_third_byte,
  output logic [7:0]       payload_ident_fourth_byte,
  output logic             vpidValid,
  output logic             vpidSumErr,
  output logic [7:0]       link_b_payload_ident_first_byte,
  output logic [7:0]       link_b_payload_ident_second_byte,
  output logic [7:0]       link_b_payload_ident_third_byte,
  output logic [7:0]       link_b_payload_ident_fourth_byte,
  output logic             vpidValidB,
  output logic             vpidSumErrB,
  output logic [10:0]      line_number_out,
  output logic [10:0]      link_b_line_number
);
  localparam int L = vrls_pkg::NLINK;

  // bus side state in one record
  typedef struct packed {
    logic                      ack;
    logic [31:0]               dat;
    logic [vrls_pkg::CTRL_W-1:0] ctrl;  // software control
    logic [vrls_pkg::IRQ_W-1:0]  iSt;   // sticky events
    logic [vrls_pkg::IRQ_W-1:0]  iMsk;  // event mask
    logic                      irq;
    logic [7:0]                dlCnt; // cycles since link A ref
    logic                      dlAl;  // last B ref near an A ref
    logic                      dlLock;
  } vrls_bus_t;

  vrls_bus_t s;
  vrls_bus_t next_s;

  // per-link gathered signals, index 0 is link A
  logic [L-1:0][9:0]  word;
  logic [L-1:0]       wv, lnv, cChk, bY, bC, vStb, vOk, rst;
  logic [L-1:0][10:0] lnIn, ln;
  logic [L-1:0][31:0] vIn, vp;
  logic [L-1:0]       trs, al, lo, tl, fl, cy, cc, vv, ve;
  logic [L-1:0]       lostEv, crcEv, sumEv;
  logic [vrls_pkg::IRQ_W-1:0] ev;   // this cycle's events
  logic               wr;           // write takes effect

  assign word = {wordB, wordA};
  assign wv   = {wordValidB, wordValidA};
  assign lnIn = {lnInB, lnInA};
  assign lnv  = {lnValidB, lnValidA};
  assign cChk = {crcChkB, crcChkA};
  assign bY   = {crcBadYB, crcBadYA};
  assign bC   = {crcBadCB, crcBadCA};
  assign vIn  = {vpidInB, vpidInA};
  assign vStb = {vpidStbB, vpidStbA};
  assign vOk  = {vpidSumOkB, vpidSumOkA};
  // link B idles in reset unless dual mode is on
  assign rst  = {srst | ~s.ctrl[vrls_pkg::CTRL_DUAL], srst};

  // one instance per link, same criteria on both
  generate
    for (genvar i = 0; i < L; i++) begin : g_link
      vrls_link u_link (
        .clk        (clk),
        .srst       (rst[i]),
        .word       (word[i]),
        .wordValid  (wv[i]),
        .lnIn       (lnIn[i]),
        .lnValid    (lnv[i]),
        .crcChk     (cChk[i]),
        .crcBadY    (bY[i]),
        .crcBadC    (bC[i]),
        .vpidIn     (vIn[i]),
        .vpidStb    (vStb[i]),
        .vpidSumOk  (vOk[i]),
        .crcEn      (s.ctrl[vrls_pkg::CTRL_CRC]),
        .vpidEn     (s.ctrl[vrls_pkg::CTRL_VPID]),
        .sdMode     (sdMode),
        .trsStart   (trs[i]),
        .alignLock  (al[i]),
        .looseLock  (lo[i]),
        .trsLock    (tl[i]),
        .frameLock  (fl[i]),
        .crcErrY    (cy[i]),
        .crcErrC    (cc[i]),
        .vpid       (vp[i]),
        .vpidValid  (vv[i]),
        .vpidSumErr (ve[i]),
        .lineNum    (ln[i]),
        .lostEv     (lostEv[i]),
        .crcEv      (crcEv[i]),
        .sumEv      (sumEv[i])
      );
    end
  endgenerate

  // bus, interrupt and dual-lock next state
  always_comb begin
    next_s = s;
    // write lands on the edge where the master samples ack high
    wr = cyc_i && stb_i && we_i && s.ack;
    // ack one cycle after the strobe, dropped after one
    next_s.ack = cyc_i && stb_i && !s.ack;
    next_s.dat = '0;
    ev = '0;
    ev[vrls_pkg::IRQ_LOST_A] = lostEv[0];
    ev[vrls_pkg::IRQ_LOST_B] = lostEv[1];
    ev[vrls_pkg::IRQ_CRC] = |crcEv;
    ev[vrls_pkg::IRQ_SUM] = |sumEv;
    if (wr && sel_i[0]) begin
      case (adr_i)
        vrls_pkg::ADR_CTRL:  next_s.ctrl =
                               dat_i[vrls_pkg::CTRL_W-1:0];
        vrls_pkg::ADR_ISTAT: next_s.iSt = s.iSt &
                               ~dat_i[vrls_pkg::IRQ_W-1:0];
        vrls_pkg::ADR_IMASK: next_s.iMsk =
                               dat_i[vrls_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
    // set wins over a clear in the same cycle
    next_s.iSt = next_s.iSt | ev;
    next_s.irq = |(next_s.iSt & next_s.iMsk);
    // read data registered with the ack
    if (cyc_i && stb_i && !we_i && !s.ack) begin
      case (adr_i)
        vrls_pkg::ADR_CTRL:   next_s.dat =
                                32'(s.ctrl);
        vrls_pkg::ADR_STAT:   next_s.dat =
                                32'({s.dlLock, fl, tl, al, lo});
        vrls_pkg::ADR_ISTAT:  next_s.dat = 32'(s.iSt);
        vrls_pkg::ADR_IMASK:  next_s.dat = 32'(s.iMsk);
        vrls_pkg::ADR_LINE_B: next_s.dat = 32'(ln[1]);
        vrls_pkg::ADR_VPID_A: next_s.dat = vp[0];
        vrls_pkg::ADR_VPID_B: next_s.dat = vp[1];
        default:              next_s.dat = '0;
      endcase
    end
    // distance from link A reference, saturating
    if (trs[0]) begin
      next_s.dlCnt = '0;
    end else if (s.dlCnt != vrls_pkg::DL_CNT_MAX) begin
      next_s.dlCnt = s.dlCnt + 8'h01;
    end
    if (trs[1]) begin
      next_s.dlAl = trs[0] || s.dlCnt <= vrls_pkg::DL_SKEW;
    end
    next_s.dlLock = s.ctrl[vrls_pkg::CTRL_DUAL] && next_s.dlAl
                    && tl[0] && tl[1];
  end

  // bus state register
  always_ff @(posedge clk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign dat_o  = s.dat;
  assign ack_o  = s.ack;
  assign irq    = s.irq;
  assign trsStart   = trs[0];
  assign trsStartB  = trs[1];
  assign alignLock  = al[0];
  assign alignLockB = al[1];
  assign trsLock    = tl[0];
  assign trsLockB   = tl[1];
  assign frameLock  = fl[0];
  assign frameLockB = fl[1];
  assign dual_link_lock = s.dlLock;
  // feeds the transceiver loose-lock input
  assign looseLock  = lo[0];
  assign looseLockB = lo[1];
  assign crcErrY    = cy[0];
  assign crcErrC    = cc[0];
  assign crcErrYB   = cy[1];
  assign crcErrCB   = cc[1];
  assign payload_ident_first_byte  = vp[0][31:24];
  assign payload_ident_second_byte = vp[0][23:16];
  assign payload_ident_third_byte  = vp[0][15:8];
  assign payload_ident_fourth_byte = vp[0][7:0];
  assign vpidValid  = vv[0];
  assign vpidSumErr = ve[0];
  assign link_b_payload_ident_first_byte  = vp[1][31:24];
  assign link_b_payload_ident_second_byte = vp[1][23:16];
  assign link_b_payload_ident_third_byte  = vp[1][15:8];
  assign link_b_payload_ident_fourth_byte = vp[1][7:0];
  assign vpidValidB  = vv[1];
  assign vpidSumErrB = ve[1];
  assign line_number_out    = ln[0];
  assign link_b_line_number = ln[1];
endmodule : vrls_top
`default_nettype wire

// ### inc/vrls_pkg.sv
`default_nettype none
package vrls_pkg;
  // word and frame counter width, sized for the longest frame
  localparam int              CNT_W       = 24;
  // timing reference pattern words
  localparam logic [9:0]      TRS_ONES    = 10'h3FF;
  localparam logic [9:0]      TRS_ZERO    = 10'h000;
  // matching references needed for reference lock
  localparam logic [2:0]      TRS_LOCK_N  = 3'h6;
  // matching frames needed for frame lock
  localparam logic [1:0]      FRAME_LOCK_N = 2'h3;
  // words without a reference before alignment is dropped
  localparam logic [CNT_W-1:0] TRS_TIMEOUT = 24'h001000;
  // line number that opens a frame
  localparam logic [10:0]     LN_FIRST    = 11'h001;
  // cycles allowed between link references for dual lock
  localparam logic [7:0]      DL_SKEW     = 8'h04;
  localparam logic [7:0]      DL_CNT_MAX  = 8'hFF;
  // register byte offsets
  localparam logic [7:0]      ADR_CTRL    = 8'h00;
  localparam logic [7:0]      ADR_STAT    = 8'h04;
  localparam logic [7:0]      ADR_ISTAT   = 8'h08;
  localparam logic [7:0]      ADR_IMASK   = 8'h0C;
  localparam logic [7:0]      ADR_LINE_B  = 8'h10;
  localparam logic [7:0]      ADR_VPID_A  = 8'h14;
  localparam logic [7:0]      ADR_VPID_B  = 8'h18;
  // control bits
  localparam int              CTRL_W      = 3;
  localparam int              CTRL_CRC    = 0;
  localparam int              CTRL_VPID   = 1;
  localparam int              CTRL_DUAL   = 2;
  // interrupt bits
  localparam int              IRQ_W       = 4;
  localparam int              IRQ_LOST_A  = 0;
  localparam int              IRQ_LOST_B  = 1;
  localparam int              IRQ_CRC     = 2;
  localparam int              IRQ_SUM     = 3;
  localparam int              NLINK       = 2;
endpackage : vrls_pkg
`default_nettype wire

// ### dv/vrls_sva.sv
`timescale 1ns/1ps
`default_nettype none
// port-level checks on locks, crc and payload flags
module vrls_chk (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic [9:0]  wordA,
  input wire logic        wordValidA,
  input wire logic        trsStart,
  input wire logic        alignLock,
  input wire logic        looseLock,
  input wire logic        trsLock,
  input wire logic        trsLockB,
  input wire logic        frameLock,
  input wire logic        dual_link_lock,
  input wire logic        sdMode,
  input wire logic        crcChkA,
  input wire logic        crcErrY,
  input wire logic        crcErrC,
  input wire logic        vpidValid,
  input wire logic        vpidSumErr,
  input wire logic        lnValidB,
  input wire logic [10:0] lnInB,
  input wire logic [10:0] link_b_line_number
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  align_on_ref_a: assert property ($rose(alignLock) |-> trsStart)
    else $error("align lock rose without a reference");
  loose_on_ref_a: assert property ($rose(looseLock) |-> trsStart)
    else $error("loose lock rose without a reference");
  ref_pattern_a: assert property (
    trsStart |-> $past(wordValidA && wordA == vrls_pkg::TRS_ZERO))
    else $error("reference mark without closing zero word");
  trs_needs_align_a: assert property (trsLock |-> alignLock)
    else $error("reference lock without alignment");
  frame_needs_trs_a: assert property ($rose(frameLock) |-> trsLock)
    else $error("frame lock without reference lock");
  dual_both_a: assert property (
    dual_link_lock |-> $past(trsLock) && $past(trsLockB))
    else $error("dual lock without both links locked");
  crc_sd_off_a: assert property (
    crcChkA && sdMode |=> !crcErrY && !crcErrC)
    else $error("crc flag raised in sd mode");
  crc_hold_a: assert property (
    !crcChkA && $stable(sdMode) |=> $stable(crcErrY) && $stable(crcErrC))
    else $error("crc flag moved without a check");
  vpid_excl_a: assert property (vpidSumErr |-> !vpidValid)
    else $error("payload valid and checksum error together");
  line_b_a: assert property (
    lnValidB && trsLockB |=> link_b_line_number == $past(lnInB))
    else $error("link b line number not taken");
  reset_clear_a: assert property (
    $fell(srst) |-> !alignLock && !trsLock && !frameLock && !vpidValid)
    else $error("indication set after reset");
  cover property ($rose(trsLock));
  cover property ($rose(frameLock));
  cover property ($rose(dual_link_lock));
endmodule : vrls_chk
bind vrls_top vrls_chk u_chk (.clk, .srst, .wordA, .wordValidA, .trsStart,
  .alignLock, .looseLock, .trsLock, .trsLockB, .frameLock, .dual_link_lock,
  .sdMode, .crcChkA, .crcErrY, .crcErrC, .vpidValid, .vpidSumErr, .lnValidB,
  .lnInB, .link_b_line_number);
`default_nettype wire

// ### dv/vrls_src.sv
`timescale 1ns/1ps
`default_nettype none
// receive side stand-in: lines of two references, steady timing
module vrls_src #(
  parameter int HALF  = 16, // words per half line
  parameter int LINES = 4   // lines per frame
) (
  input  wire logic  clk,
  input  wire logic  run,
  input  wire logic  stretch,
  output logic [9:0]  word,
  output logic        wordValid,
  output logic [10:0] lnIn,
  output logic        lnValid
);
  int pos;  // word index in half line
  int half; // which half of the line
  int ln;   // line being sent
  initial begin
    {word, wordValid, lnIn, lnValid} = '0;
    pos = 0;
    half = 0;
    ln = 1;
  end
  // stretch adds one word to a half line to upset timing on purpose
  always @(posedge clk) begin
    lnValid <= 1'b0;
    lnIn    <= ~lnIn; // no stale line number between strobes
    if (!run) begin
      wordValid <= 1'b0;
      word      <= ~word; // idle lines keep toggling
    end else begin
      wordValid <= 1'b1;
      case (pos)
        0:       word <= vrls_pkg::TRS_ONES;
        1, 2:    word <= vrls_pkg::TRS_ZERO;
        default: word <= 10'h200 | 10'(pos);
      endcase
      if (pos == 3 && half == 0) begin
        lnValid <= 1'b1;
        lnIn    <= 11'(ln);
      end
      if (pos < HALF - 1 + int'(stretch)) pos <= pos + 1;
      else begin
        pos  <= 0;
        half <= 1 - half;
        if (half == 1) ln <= (ln == LINES) ? 1 : ln + 1;
      end
    end
  end
endmodule : vrls_src
`default_nettype wire

// ### dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk, srst, cyc_i, stb_i, we_i, ack_o, irq, sdMode, run;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o, vpidInA, vpidInB, rd;
  logic [9:0]  wordA, wordB;
  logic [10:0] lnInA, lnInB, line_number_out, link_b_line_number;
  logic wordValidA, lnValidA, crcChkA, crcBadYA, crcBadCA, vpidStbA;
  logic wordValidB, lnValidB, crcChkB, crcBadYB, crcBadCB, vpidStbB;
  logic trsStart, trsStartB, alignLock, alignLockB, trsLock, trsLockB;
  logic frameLock, frameLockB, dual_link_lock, looseLock, looseLockB;
  logic crcErrY, crcErrC, crcErrYB, crcErrCB, vpidValid, vpidSumErr;
  logic vpidValidB, vpidSumErrB, vpidSumOkA, vpidSumOkB, stretch;
  logic [7:0] payload_ident_first_byte, payload_ident_second_byte;
  logic [7:0] payload_ident_third_byte, payload_ident_fourth_byte;
  logic [7:0] link_b_payload_ident_first_byte;
  logic [7:0] link_b_payload_ident_second_byte;
  logic [7:0] link_b_payload_ident_third_byte;
  logic [7:0] link_b_payload_ident_fourth_byte;
  int badCount, checksDone;

  vrls_top i_vrls_top (.*);
  vrls_src i_vrls_src (.clk, .run, .stretch, .word(wordA),
    .wordValid(wordValidA), .lnIn(lnInA), .lnValid(lnValidA));
  vrls_src i_vrls_src_b (.clk, .run, .stretch(1'b0), .word(wordB),
    .wordValid(wordValidB), .lnIn(lnInB), .lnValid(lnValidB));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checksDone++;
    if (g !== e) begin
      badCount++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wrapUp();
    if (badCount == 0 && checksDone > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrapUp

  // classic single cycle: held until ack, then a cycle released
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc_i <= 1'b1;
    sel_i <= 4'hF;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    rd = dat_o;
    if (ack_o !== 1'b1) chk("ack", 32'h1, 32'h0);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk);
  endtask : wb

  // wait up to a bound for a level to reach a value
  task automatic waitFor(ref logic s, input logic v, input int lim);
    for (int n = 0; n < lim && s !== v; n++) begin
      @(posedge clk);
      #1;
    end
  endtask : waitFor

  // nothing set out of reset; unmapped place reads zero
  task automatic tReset();
    wb(1'b0, vrls_pkg::ADR_STAT, 32'h0);
    chk("stat", 32'h0, rd);
    wb(1'b1, 8'h40, 32'hFFFFFFFF);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("irq", 32'h0, {31'h0, irq});
  endtask : tReset

  // count references up to lock, then frame and dual lock
  task automatic tLock();
    int refs;
    refs = 0;
    wb(1'b1, vrls_pkg::ADR_CTRL, 32'h7);
    run <= 1'b1;
    for (int n = 0; n < 400 && trsLock !== 1'b1; n++) begin
      @(posedge clk);
      #1;
      if (trsStart === 1'b1) refs++;
      if (refs == 1 && trsStart === 1'b1)
        chk("first ref", 32'h1F, {27'h0, alignLock, looseLock, trsStartB,
          alignLockB, looseLockB});
    end
    // first interval runs from reset, two more before a match
    chk("refs", 32'(vrls_pkg::TRS_LOCK_N) + 32'h3, refs);
    waitFor(frameLock, 1'b1, 2000);
    repeat (4) @(posedge clk);
    wb(1'b0, vrls_pkg::ADR_STAT, 32'h0);
    chk("stat", 32'h1FF, rd);
    // every lock pin, dual lock down to loose lock, as the transceiver would take them
    chk("pins", 32'h1FF, {23'h0, dual_link_lock, frameLockB, frameLock,
      trsLockB, trsLock, alignLockB, alignLock, looseLockB,
      looseLock});
    chk("lines", 32'h3, {30'h0, line_number_out inside {[1:4]},
      link_b_line_number inside {[1:4]}});
  endtask : tLock

  // one check on both links, mismatches crossed between links
  task automatic crc(input logic sd, input logic y, input logic c);
    @(posedge clk);
    sdMode   <= sd;
    crcChkA  <= 1'b1;
    crcChkB  <= 1'b1;
    crcBadYA <= y;
    crcBadCA <= c;
    crcBadYB <= c;
    crcBadCB <= y;
    @(posedge clk);
    crcChkA <= 1'b0;
    crcChkB <= 1'b0;
    @(posedge clk);
    #1;
    chk("crc a", {30'h0, y & !sd, c & !sd}, {30'h0, crcErrY, crcErrC});
    chk("crc b", {30'h0, c & !sd, y & !sd}, {30'h0, crcErrYB, crcErrCB});
  endtask : crc

  // every crc case, then interrupt masked, raised, cleared
  task automatic tCrc();
    for (int i = 0; i < 8; i++) crc(i[2], i[1], i[0]);
    @(posedge clk);
    sdMode <= 1'b0;
    chk("irq masked", 32'h0, {31'h0, irq});
    wb(1'b1, vrls_pkg::ADR_IMASK, 32'h4);
    @(posedge clk);
    #1;
    chk("irq on", 32'h1, {31'h0, irq});
    wb(1'b1, vrls_pkg::ADR_ISTAT, 32'h4);
    @(posedge clk);
    #1;
    chk("irq off", 32'h0, {31'h0, irq});
    wb(1'b0, vrls_pkg::ADR_ISTAT, 32'h0);
    chk("istat crc", 32'h0, rd & 32'h4);
  endtask : tCrc

  // payload id on both links, link b gets the inverse bytes
  task automatic vp(input logic ok, input logic [31:0] d);
    @(posedge clk);
    vpidInA    <= d;
    vpidInB    <= ~d;
    vpidSumOkA <= ok;
    vpidSumOkB <= ok;
    vpidStbA   <= 1'b1;
    vpidStbB   <= 1'b1;
    @(posedge clk);
    vpidStbA <= 1'b0;
    vpidStbB <= 1'b0;
    #1;
    chk("vpid a", d, {payload_ident_first_byte, payload_ident_second_byte,
      payload_ident_third_byte, payload_ident_fourth_byte});
    chk("vpid b", ~d, {link_b_payload_ident_first_byte,
      link_b_payload_ident_second_byte, link_b_payload_ident_third_byte,
      link_b_payload_ident_fourth_byte});
    chk("vpid flags", {28'h0, ok, !ok, ok, !ok}, {28'h0, vpidValid,
      vpidSumErr, vpidValidB, vpidSumErrB});
  endtask : vp

  // payload id and crc switched off: stale payload checksum error flags go off on both links
  task automatic tOff();
    wb(1'b1, vrls_pkg::ADR_CTRL, 32'h4);
    @(posedge clk);
    #1;
    chk("vpid off", 32'h0, {30'h0, vpidSumErr, vpidSumErrB});
  endtask : tOff

  // one long half line must cost reference and frame lock
  task automatic tDrop();
    waitFor(trsStart, 1'b1, 100);
    stretch <= 1'b1;
    repeat (16) @(posedge clk);
    stretch <= 1'b0;
    waitFor(trsLock, 1'b0, 200);
    chk("lock drop", 32'h0, {30'h0, trsLock, frameLock});
    wb(1'b0, vrls_pkg::ADR_ISTAT, 32'h0);
    chk("lost a", 32'h1, rd & 32'h1);
  endtask : tDrop

  initial begin
    {cyc_i, stb_i, we_i, sdMode, run, stretch} = '0;
    {crcChkA, crcBadYA, crcBadCA, vpidStbA, vpidSumOkA} = '0;
    {crcChkB, crcBadYB, crcBadCB, vpidStbB, vpidSumOkB} = '0;
    {adr_i, dat_i, vpidInA, vpidInB} = '0;
    sel_i = 4'hF;
    srst = 1'b1;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    tReset();
    tLock();
    tCrc();
    vp(1'b1, 32'h89ABCDEF);
    vp(1'b0, 32'h13579BDF);
    tOff();
    tDrop();
    wrapUp();
  end

  // cut a hang short well past the expected run
  initial begin
    repeat (20000) @(posedge clk);
    badCount++;
    wrapUp();
  end
endmodule : testbench
`default_nettype wire
